//--- design/modem_cfg_pkg.sv
// constants shared by the modem format/sync register bank and its sync qualifier
// assumes an 8-bit register port with 6-bit addresses, one clock domain
package modem_cfg_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [5:0] FMT_ADDR = 6'h12;
    localparam logic [5:0] SPC_ADDR = 6'h13;
    localparam logic [7:0] FMT_RESET = 8'h02;
    localparam logic [7:0] SPC_RESET = 8'h02;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam int DCF_BIT = 7;
    localparam int MOD_HI = 6;
    localparam int MOD_LO = 4;
    localparam int MAN_BIT = 3;
    localparam int SQM_HI = 2;
    localparam int SQM_LO = 0;
    localparam int SPC_TOOL_BIT = 7;
    localparam int SPC_E_HI = 1;
    localparam int SPC_E_LO = 0;
    localparam logic [2:0] MOD_2FSK = 3'h0;
    localparam logic [2:0] MOD_GFSK = 3'h1;
    localparam logic [2:0] MOD_OOK = 3'h3;
    localparam logic [2:0] MOD_4FSK = 3'h4;
    // low two bits of the qualifier mode select the criterion, bit 2 adds carrier sense
    localparam logic [1:0] CRIT_NONE = 2'h0;
    localparam logic [1:0] CRIT_16_LOOSE = 2'h1;
    localparam logic [1:0] CRIT_16_STRICT = 2'h2;
    localparam logic [1:0] CRIT_32 = 2'h3;
    localparam int CS_BIT = 2;
    localparam logic [5:0] NEED_16_LOOSE = 6'h0F;
    localparam logic [5:0] NEED_16_STRICT = 6'h10;
    localparam logic [5:0] NEED_32 = 6'h1E;
    localparam int SYNC_W = 16;
    localparam int SHIFT_W = 32;
    localparam logic [8:0] SPC_HIDDEN_ONE = 9'h100;
    localparam int OFFSET_W = 20;
endpackage : modem_cfg_pkg

//--- design/sync_qualifier.sv
// sync word search with match-count thresholds and optional carrier-sense gate
// assumes received bits arrive from the demodulator on the same clock
`timescale 1ns/1ps
module sync_qualifier (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] qual_mode,
    input wire logic rx_bit,
    input wire logic rx_bit_valid,
    input wire logic carrier_sense,
    input wire logic [modem_cfg_pkg::SYNC_W-1:0] sync_word,
    output logic sync_found_r,
    output logic search_active_r
);
    import modem_cfg_pkg::*;

    function automatic logic [5:0] ones32(input logic [31:0] v);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) begin
            n = n + {5'h00, v[i]};
        end
        return n;
    endfunction : ones32

    logic [SHIFT_W-1:0] shift_r;
    logic [SHIFT_W-1:0] shift_nxt;
    logic sync_found_nxt;
    logic search_active_nxt;
    logic [5:0] ones16;
    logic [5:0] ones_all;
    logic crit_met;
    logic [1:0] crit;

    always_comb begin
        crit = qual_mode[1:0];
        shift_nxt = shift_r;
        if (rx_bit_valid) begin
            shift_nxt = {shift_r[SHIFT_W-2:0], rx_bit};
        end
        ones16 = ones32({16'h0000, ~(shift_nxt[SYNC_W-1:0] ^ sync_word)});
        // 32-bit criterion expects the 16-bit word twice
        ones_all = ones32(~(shift_nxt ^ {sync_word, sync_word}));
        case (crit)
            CRIT_16_LOOSE: crit_met = ones16 >= NEED_16_LOOSE;
            CRIT_16_STRICT: crit_met = ones16 >= NEED_16_STRICT;
            CRIT_32: crit_met = ones_all >= NEED_32;
            default: crit_met = 1'b0;
        endcase
        search_active_nxt = crit != CRIT_NONE;
        sync_found_nxt = rx_bit_valid && crit_met && (!qual_mode[CS_BIT] || carrier_sense);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_r <= '0;
            sync_found_r <= 1'b0;
            search_active_r <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            sync_found_r <= sync_found_nxt;
            search_active_r <= search_active_nxt;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    no_sync_search_a: assert property (@(posedge clk) disable iff (rst)
        ($past(qual_mode[1:0]) == CRIT_NONE) |-> !sync_found_r && !search_active_r)
        else $error("sync search ran in a no-sync mode");
    loose16_match_a: assert property (@(posedge clk) disable iff (rst)
        (sync_found_r && $past(qual_mode[1:0]) == CRIT_16_LOOSE) |-> $past(ones16) >= NEED_16_LOOSE)
        else $error("15 of 16 criterion violated");
    strict16_match_a: assert property (@(posedge clk) disable iff (rst)
        (sync_found_r && $past(qual_mode[1:0]) == CRIT_16_STRICT) |-> $past(ones16) == NEED_16_STRICT)
        else $error("16 of 16 criterion violated");
    wide32_match_a: assert property (@(posedge clk) disable iff (rst)
        (sync_found_r && $past(qual_mode[1:0]) == CRIT_32) |-> $past(ones_all) >= NEED_32)
        else $error("30 of 32 criterion violated");
    cs_gate_a: assert property (@(posedge clk) disable iff (rst)
        (sync_found_r && $past(qual_mode[CS_BIT])) |-> $past(carrier_sense))
        else $error("sync accepted without carrier sense");
    loose_hit_c: cover property (@(posedge clk) disable iff (rst)
        sync_found_r && $past(qual_mode) == 3'h1 && $past(ones16) == 6'h0F);
    wide_hit_c: cover property (@(posedge clk) disable iff (rst)
        sync_found_r && $past(qual_mode) == 3'h7);
endmodule : sync_qualifier

//--- design/modem_format_sync_config.sv
// modem format/sync and channel spacing exponent registers with their consumers' decode
// assumes the serial port decoder presents single-cycle 8-bit reads and writes on clk
`timescale 1ns/1ps
module modem_format_sync_config (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [modem_cfg_pkg::ADDR_W-1:0] addr,
    input wire logic [modem_cfg_pkg::DATA_W-1:0] wdata,
    output logic [modem_cfg_pkg::DATA_W-1:0] rdata_r,
    output logic rd_valid_r,
    output logic dc_block_bypass_r,
    output logic [2:0] modulation_select_r,
    output logic manchester_enable_r,
    output logic [2:0] sync_qual_mode_r,
    output logic [1:0] channel_spacing_exponent_r,
    output logic spacing_tool_bit_r,
    input wire logic [7:0] channel_spacing_mantissa,
    input wire logic [7:0] channel_number,
    output logic [modem_cfg_pkg::OFFSET_W-1:0] channel_offset_r,
    input wire logic rx_bit,
    input wire logic rx_bit_valid,
    input wire logic carrier_sense,
    input wire logic [modem_cfg_pkg::SYNC_W-1:0] sync_word,
    output logic sync_found_r,
    output logic search_active_r
);
    import modem_cfg_pkg::*;

    // ************************************************************
    // register file
    // ************************************************************
    logic [7:0] fmt_r;
    logic [7:0] fmt_nxt;
    logic [7:0] spc_r;
    logic [7:0] spc_nxt;
    logic [7:0] rdata_nxt;
    logic rd_valid_nxt;
    logic [OFFSET_W-1:0] offset_nxt;
    logic [11:0] spacing_step;

    always_comb begin
        fmt_nxt = fmt_r;
        spc_nxt = spc_r;
        if (wr_en && addr == FMT_ADDR) begin
            fmt_nxt = wdata;
        end
        if (wr_en && addr == SPC_ADDR) begin
            spc_nxt = READ_ZERO;
            spc_nxt[SPC_TOOL_BIT] = wdata[SPC_TOOL_BIT];
            spc_nxt[SPC_E_HI:SPC_E_LO] = wdata[SPC_E_HI:SPC_E_LO];
        end
        rd_valid_nxt = rd_en;
        rdata_nxt = READ_ZERO;
        if (rd_en) begin
            case (addr)
                FMT_ADDR: rdata_nxt = fmt_r;
                SPC_ADDR: rdata_nxt = spc_r;
                default: rdata_nxt = READ_ZERO;
            endcase
        end
        // spacing in fref/2^18 units, then scaled by channel number
        spacing_step = 12'({3'h0, SPC_HIDDEN_ONE | {1'b0, channel_spacing_mantissa}}
            << spc_r[SPC_E_HI:SPC_E_LO]);
        // widen both factors first so the product is never cut to 12 bits
        offset_nxt = OFFSET_W'(spacing_step) * OFFSET_W'(channel_number);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fmt_r <= FMT_RESET;
            spc_r <= SPC_RESET;
            rdata_r <= READ_ZERO;
            rd_valid_r <= 1'b0;
            channel_offset_r <= '0;
        end else begin
            fmt_r <= fmt_nxt;
            spc_r <= spc_nxt;
            rdata_r <= rdata_nxt;
            rd_valid_r <= rd_valid_nxt;
            channel_offset_r <= offset_nxt;
        end
    end

    // ************************************************************
    // decoded fields
    // ************************************************************
    always_comb begin
        dc_block_bypass_r = fmt_r[DCF_BIT];
        modulation_select_r = fmt_r[MOD_HI:MOD_LO];
        manchester_enable_r = fmt_r[MAN_BIT];
        sync_qual_mode_r = fmt_r[SQM_HI:SQM_LO];
        channel_spacing_exponent_r = spc_r[SPC_E_HI:SPC_E_LO];
        spacing_tool_bit_r = spc_r[SPC_TOOL_BIT];
    end

    sync_qualifier u_sync (
        .clk(clk),
        .rst(rst),
        .qual_mode(fmt_r[SQM_HI:SQM_LO]),
        .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid),
        .carrier_sense(carrier_sense),
        .sync_word(sync_word),
        .sync_found_r(sync_found_r),
        .search_active_r(search_active_r)
    );

    // ************************************************************
    // checks
    // ************************************************************
    dc_bypass_write_a: assert property (@(posedge clk) disable iff (rst)
        (wr_en && addr == FMT_ADDR) |=> dc_block_bypass_r == $past(wdata[DCF_BIT]))
        else $error("dc bypass bit not written");
    mod_select_write_a: assert property (@(posedge clk) disable iff (rst)
        (wr_en && addr == FMT_ADDR) |=> modulation_select_r == $past(wdata[MOD_HI:MOD_LO]))
        else $error("modulation field not written");
    manchester_hold_a: assert property (@(posedge clk) disable iff (rst)
        !(wr_en && addr == FMT_ADDR) |=> manchester_enable_r == $past(manchester_enable_r))
        else $error("manchester bit changed without a write");
    spacing_read_a: assert property (@(posedge clk) disable iff (rst)
        (rd_en && addr == SPC_ADDR) |=> rd_valid_r && rdata_r[SPC_TOOL_BIT-1:SPC_E_HI+1] == 5'h00
            && rdata_r[SPC_E_HI:SPC_E_LO] == $past(channel_spacing_exponent_r))
        else $error("spacing register readback wrong");
    chan_offset_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> channel_offset_r == OFFSET_W'((($past(channel_spacing_mantissa) + 20'h100)
            << $past(channel_spacing_exponent_r)) * $past(channel_number)))
        else $error("channel offset mismatch");
    fmt_read_c: cover property (@(posedge clk) disable iff (rst) rd_en && addr == FMT_ADDR);
    fourfsk_c: cover property (@(posedge clk) disable iff (rst) modulation_select_r == MOD_4FSK);
endmodule : modem_format_sync_config

//--- testbench/host_port_model.sv
// host model driving the modem config register port
// assumes its tasks are entered 1 ns after a rising clk edge
`timescale 1ns/1ps
module host_port_model (
    input wire logic clk,
    output logic wr_en,
    output logic rd_en,
    output logic [5:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata_r,
    input wire logic rd_valid_r
);
    import modem_cfg_pkg::*;
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 6'h3F;
        wdata = 8'h00;
    end
    task automatic write(input logic [5:0] a, input logic [7:0] d);
        wr_en = 1'b1;
        addr = a;
        // manchester dropped with 4-fsk; every other write, format and bypass bit included, is sent unchanged
        wdata = (a == FMT_ADDR && d[MOD_HI:MOD_LO] == MOD_4FSK) ? (d & 8'hF7) : d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        addr = ~a;
        wdata = ~wdata;
    endtask : write
    task automatic read(input logic [5:0] a, output logic [7:0] d, output bit ok);
        rd_en = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        rd_en = 1'b0;
        addr = ~a;
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rd_valid_r === 1'b1) begin
                ok = 1'b1;
                d = rdata_r;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask : read
endmodule : host_port_model

//--- testbench/tb_modem_format_sync_config.sv
// self-checking bench for the modem format/sync register bank
// assumes host_port_model drives the register port
`timescale 1ns/1ps
module tb_modem_format_sync_config;
    import modem_cfg_pkg::*;
    logic clk, rst, wr_en, rd_en, rd_valid_r, dcb, man, tool, rx_bit, rx_v, cs, found, act, ok;
    logic [5:0] addr;
    logic [7:0] wdata, rdata_r, mant, chan, d;
    logic [2:0] mods, qm;
    logic [1:0] expo;
    logic [19:0] offs;
    logic [15:0] sw;
    logic [7:0] fmts [4] = '{8'h89, 8'h1B, 8'hB2, 8'h46};
    int n_mismatch = 0;
    int num_checks = 0;
    host_port_model host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .rdata_r(rdata_r), .rd_valid_r(rd_valid_r));
    modem_format_sync_config dut_u (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .rdata_r(rdata_r), .rd_valid_r(rd_valid_r), .dc_block_bypass_r(dcb),
        .modulation_select_r(mods), .manchester_enable_r(man), .sync_qual_mode_r(qm),
        .channel_spacing_exponent_r(expo), .spacing_tool_bit_r(tool), .channel_spacing_mantissa(mant),
        .channel_number(chan), .channel_offset_r(offs), .rx_bit(rx_bit), .rx_bit_valid(rx_v),
        .carrier_sense(cs), .sync_word(sw), .sync_found_r(found), .search_active_r(act));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        host_u.read(a, d, ok);
        if (!ok) begin
            n_mismatch++;
            $display("Error %0t: read answer missing", $time);
            test_done();
        end else begin
            chk(d, e);
        end
    endtask : rd_chk
    // ****************************************
    // sync search: send n bits msb first, check last one
    // ****************************************
    task automatic sq(input logic [2:0] m, input logic c, input logic [31:0] flip, input int n, input logic e);
        logic [31:0] pat;
        host_u.write(FMT_ADDR, {5'h00, m});
        cs = c;
        pat = {sw, sw} ^ flip;
        for (int i = n - 1; i >= 0; i--) begin
            rx_bit = pat[i];
            rx_v = 1'b1;
            @(posedge clk);
            #1;
        end
        rx_v = 1'b0;
        chk(found, e);
        chk(act, m[1:0] != 2'h0);
    endtask : sq
    initial begin
        rst = 1'b1;
        rx_bit = 1'b0;
        rx_v = 1'b0;
        cs = 1'b0;
        mant = 8'hF8;
        chan = 8'h00;
        sw = 16'hD391;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        chk({dcb, mods, man, qm}, FMT_RESET);
        chk({tool, expo}, 3'h2);
        rd_chk(FMT_ADDR, FMT_RESET);
        rd_chk(SPC_ADDR, SPC_RESET);
        foreach (fmts[i]) begin
            host_u.write(FMT_ADDR, fmts[i]);
            chk({dcb, mods, man, qm}, fmts[i]);
            rd_chk(FMT_ADDR, fmts[i]);
        end
        host_u.write(SPC_ADDR, 8'hFF);
        rd_chk(SPC_ADDR, 8'h83);
        chk({tool, expo}, 3'h7);
        host_u.write(6'h20, 8'hAA);
        rd_chk(6'h20, 8'h00);
        rd_chk(FMT_ADDR, 8'h46);
        chan = 8'h03;
        @(posedge clk);
        #1;
        chk(offs, 20'd12096);
        host_u.write(SPC_ADDR, 8'h00);
        mant = 8'h00;
        chan = 8'hFF;
        @(posedge clk);
        #1;
        chk(offs, 20'd65280);
        sq(3'h2, 1'b0, 32'h0, 16, 1'b1);
        sq(3'h2, 1'b0, 32'h1, 16, 1'b0);
        sq(3'h1, 1'b0, 32'h1, 16, 1'b1);
        sq(3'h1, 1'b0, 32'h3, 16, 1'b0);
        sq(3'h3, 1'b0, 32'h0100_0001, 32, 1'b1);
        sq(3'h3, 1'b0, 32'h0100_0101, 32, 1'b0);
        sq(3'h6, 1'b0, 32'h0, 16, 1'b0);
        sq(3'h6, 1'b1, 32'h0, 16, 1'b1);
        sq(3'h5, 1'b1, 32'h1, 16, 1'b1);
        sq(3'h7, 1'b1, 32'h0100_0001, 32, 1'b1);
        sq(3'h4, 1'b1, 32'h0, 16, 1'b0);
        sq(3'h0, 1'b0, 32'h0, 16, 1'b0);
        test_done();
    end
endmodule : tb_modem_format_sync_config
